// ==== core/tec_regs.vh ====
`ifndef TEC_REGS_VH
`define TEC_REGS_VH

// Register byte offsets.
`define TEC_ADDR_W        8
`define TEC_REG_CTRL      8'h00
`define TEC_REG_FRAMES    8'h04
`define TEC_REG_EXPOSE    8'h08
`define TEC_REG_CMD       8'h0c
`define TEC_REG_STATUS    8'h10

// Control register fields.
`define TEC_CTRL_SRC_LO   0
`define TEC_CTRL_SRC_HI   1
`define TEC_CTRL_EDGE     2
`define TEC_CTRL_RATE     3
`define TEC_CTRL_BIN_LO   4
`define TEC_CTRL_BIN_HI   5
`define TEC_CTRL_RST      6'h00

// Trigger source encodings.
`define TEC_SRC_NONE      2'h0
`define TEC_SRC_STD       2'h1
`define TEC_SRC_LEVEL     2'h2

// Command register bits.
`define TEC_CMD_START     0
`define TEC_CMD_STOP      1

// Frame count and exposure time widths and reset values.
`define TEC_FRM_W         16
`define TEC_FRM_RST       16'h0001
`define TEC_EXP_W         24
`define TEC_EXP_RST       24'h0003e8

// Status register fields.
`define TEC_ST_STATE_LO   0
`define TEC_ST_STATE_HI   1
`define TEC_ST_ARMED      2
`define TEC_ST_RO_BUSY    3
`define TEC_ST_RO_PEND    4
`define TEC_ST_STROBE     5
`define TEC_ST_MODE_LO    6
`define TEC_ST_MODE_HI    7
`define TEC_ST_DONE_LO    16
`define TEC_ST_DONE_HI    31

// Exposure timing: one exposure unit is one microsecond.
`define TEC_UNIT_NS       1000
`define TEC_CLK_NS        8
`define TEC_SYNC_STAGES   3

`endif

// ==== core/tec_sync.v ====
`timescale 1ns/1ps
`include "tec_regs.vh"

module tec_sync (
	// Clock and reset.
	input  wire sys_clk_i,
	input  wire reset_i,
	// Asynchronous level in, synchronised level out.
	input  wire async_i,
	output wire sync_o
);
	reg [`TEC_SYNC_STAGES-1:0] stage_r;

	// The first stage feeds only the second, so metastability settles before use.
	always @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			stage_r[0] <= 1'b0;
		end else begin
			stage_r[0] <= async_i;
		end
	end

	genvar g;
	generate
		for (g = 1; g < `TEC_SYNC_STAGES; g = g + 1) begin : g_stage
			always @(posedge sys_clk_i or posedge reset_i) begin
				if (reset_i) begin
					stage_r[g] <= 1'b0;
				end else begin
					stage_r[g] <= stage_r[g-1];
				end
			end
		end
	endgenerate

	assign sync_o = stage_r[`TEC_SYNC_STAGES-1];
endmodule // tec_sync

// ==== core/tec_timer.v ====
`timescale 1ns/1ps
`include "tec_regs.vh"

module tec_timer (
	// Clock and reset.
	input  wire                  sys_clk_i,
	input  wire                  reset_i,
	// Control.
	input  wire                  start_i,
	input  wire                  clear_i,
	input  wire [`TEC_EXP_W-1:0] length_i,
	// Expiry pulse.
	output reg                   done_o
);
	localparam integer UNIT_CYC = `TEC_UNIT_NS / `TEC_CLK_NS;
	localparam integer PRE_LAST = UNIT_CYC - 1;

	reg                  run_r;
	reg [7:0]            pre_r;
	reg [`TEC_EXP_W-1:0] cnt_r;

	// Prescale to whole units, then count units; a zero length ends after one unit.
	always @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			run_r  <= 1'b0;
			pre_r  <= 8'h00;
			cnt_r  <= {`TEC_EXP_W{1'b0}};
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (clear_i) begin
				run_r <= 1'b0;
			end else if (start_i) begin
				run_r <= 1'b1;
				pre_r <= 8'h00;
				cnt_r <= {`TEC_EXP_W{1'b0}};
			end else if (run_r) begin
				if (pre_r == PRE_LAST[7:0]) begin
					pre_r <= 8'h00;
					if (cnt_r + 1'b1 >= length_i) begin
						run_r  <= 1'b0;
						done_o <= 1'b1;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end else begin
					pre_r <= pre_r + 8'h01;
				end
			end
		end
	end
endmodule // tec_timer

// ==== core/tec_top.v ====
// Function
// - Asynchronous mode: trigger edge starts one preset-length exposure, then readout.
// - Asynchronous and bulb modes ignore the trigger while a frame reads out.
// - Asynchronous mode stays armed and returns to the wait state after readout for a fresh trigger edge.
// - Bulb mode exposes while the trigger is active; the source sets duration.
// - Strobe output is high for exactly the duration of each exposure.
// - Source none: capture command takes the configured frame count, no trigger.
// - Source standard with count zero or above one selects streaming overlap.
// - Source standard with count one selects asynchronous triggered mode.
// - Level-timed source selects bulb mode, duration from trigger pulse width.
// - Edge select picks rising or falling trigger activation.
// - Trigger behaviour ignores readout rate and binning.
`timescale 1ns/1ps
`include "tec_regs.vh"

module tec_top (
	// Clock and reset.
	input  wire                    sys_clk_i,
	input  wire                    reset_i,
	// Register port.
	input  wire [`TEC_ADDR_W-1:0]  addr_i,
	input  wire [31:0]             wr_data_i,
	input  wire                    wr_i,
	input  wire                    rd_i,
	output reg  [31:0]             rd_data_o,
	// External trigger and exposure strobe.
	input  wire                    trigger_i,
	output reg                     strobe_o,
	// Readout engine handshake and settings.
	output reg                     readout_req_o,
	input  wire                    readout_done_i,
	output reg                     readout_rate_o,
	output reg  [1:0]              binning_o
);
	// Acquisition states.
	localparam [1:0] ST_IDLE   = 2'h0;
	localparam [1:0] ST_WAIT   = 2'h1;
	localparam [1:0] ST_EXPOSE = 2'h2;
	localparam [1:0] ST_DRAIN  = 2'h3;

	// Operating modes.
	localparam [1:0] MD_SW     = 2'h0;
	localparam [1:0] MD_STREAM = 2'h1;
	localparam [1:0] MD_ASYNC  = 2'h2;
	localparam [1:0] MD_BULB   = 2'h3;

	// Mode from trigger source and frame count; readout settings play no part.
	// The unused source code falls to software mode rather than to an undefined state.
	function [1:0] tec_mode;
		input [1:0]            src;
		input [`TEC_FRM_W-1:0] frames;
		begin
			if (src == `TEC_SRC_STD) begin
				if (frames == `TEC_FRM_RST) begin
					tec_mode = MD_ASYNC;
				end else begin
					tec_mode = MD_STREAM;
				end
			end else if (src == `TEC_SRC_LEVEL) begin
				tec_mode = MD_BULB;
			end else begin
				tec_mode = MD_SW;
			end
		end
	endfunction

	// Configuration registers.
	reg [1:0]            trigger_source_select_r;
	reg                  trigger_edge_select_r;
	reg [`TEC_FRM_W-1:0] frames_r;
	reg [`TEC_EXP_W-1:0] expose_r;

	// Sequencer state and next values.
	reg [1:0]            state_r;
	reg [1:0]            state_nxt;
	reg                  armed_r;
	reg                  armed_nxt;
	reg                  ro_busy_r;
	reg                  ro_busy_nxt;
	reg                  ro_pend_r;
	reg                  ro_pend_nxt;
	reg                  ro_req_nxt;
	reg [`TEC_FRM_W-1:0] done_cnt_r;
	reg [`TEC_FRM_W-1:0] done_cnt_nxt;
	reg                  act_d_r;
	reg                  tmr_go;
	reg                  finish;
	reg                  limit_hit;

	wire                 trig_s;
	wire                 tmr_done;
	wire                 trig_act;
	wire                 start_edge;
	wire [1:0]           mode;
	wire                 cmd_wr;
	wire                 cmd_start;
	wire                 cmd_stop;
	wire                 tmr_clr;
	wire [31:0]          status_w;

	tec_sync u_sync (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.async_i   (trigger_i),
		.sync_o    (trig_s)
	);

	tec_timer u_timer (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.start_i   (tmr_go),
		.clear_i   (tmr_clr),
		.length_i  (expose_r),
		.done_o    (tmr_done)
	);

	// Polarity folds into one active-high level; edges seen only after sync.
	assign trig_act   = trigger_edge_select_r ? trig_s : ~trig_s;
	assign start_edge = trig_act & ~act_d_r;
	assign mode       = tec_mode(trigger_source_select_r, frames_r);
	assign cmd_wr     = wr_i && (addr_i == `TEC_REG_CMD);
	assign cmd_start  = cmd_wr && wr_data_i[`TEC_CMD_START];
	assign cmd_stop   = cmd_wr && wr_data_i[`TEC_CMD_STOP];
	// Stopping the timer as exposing ends keeps a late expiry from cutting the next exposure short.
	assign tmr_clr    = (state_r == ST_EXPOSE) && (state_nxt != ST_EXPOSE);

	// Sequencer next-state logic.
	always @* begin
		state_nxt    = state_r;
		armed_nxt    = armed_r;
		ro_busy_nxt  = ro_busy_r;
		ro_pend_nxt  = ro_pend_r;
		ro_req_nxt   = 1'b0;
		done_cnt_nxt = done_cnt_r;
		tmr_go       = 1'b0;
		finish       = 1'b0;
		limit_hit    = 1'b0;

		// A finished readout frees the engine; a new request below wins over it.
		if (readout_done_i) begin
			ro_busy_nxt = 1'b0;
		end
		if (cmd_stop) begin
			armed_nxt = 1'b0;
		end

		case (state_r)
			ST_IDLE: begin
				if (cmd_start) begin
					armed_nxt    = 1'b1;
					done_cnt_nxt = {`TEC_FRM_W{1'b0}};
					if (mode == MD_SW) begin
						state_nxt = ST_EXPOSE;
						tmr_go    = 1'b1;
					end else begin
						state_nxt = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				// STOP wins over a trigger edge that arrives in the same cycle.
				if (cmd_stop) begin
					state_nxt = ST_IDLE;
				end else if (mode == MD_SW) begin
					state_nxt = ST_EXPOSE;
					tmr_go    = 1'b1;
				end else if (start_edge && !ro_pend_r) begin
					// Streaming may start here while the engine is still reading.
					state_nxt = ST_EXPOSE;
					tmr_go    = 1'b1;
				end
			end
			ST_EXPOSE: begin
				if (mode == MD_BULB) begin
					finish = ~trig_act | cmd_stop;
				end else begin
					finish = tmr_done | cmd_stop;
				end
				if (finish) begin
					done_cnt_nxt = done_cnt_r + 1'b1;
					ro_pend_nxt  = 1'b1;
					limit_hit    = ((mode == MD_SW) || (mode == MD_STREAM)) &&
					               (frames_r != {`TEC_FRM_W{1'b0}}) &&
					               (done_cnt_nxt == frames_r);
					if (limit_hit) begin
						armed_nxt = 1'b0;
					end
					if (mode == MD_STREAM && !limit_hit && !cmd_stop) begin
						state_nxt = ST_WAIT;
					end else begin
						state_nxt = ST_DRAIN;
					end
				end
			end
			default: begin
				// Trigger edges are not looked at until the readout is over.
				// Software mode chains its next frame from here without any trigger.
				if (!ro_pend_r && !ro_busy_r) begin
					if (!armed_r || cmd_stop) begin
						state_nxt = ST_IDLE;
					end else if (mode == MD_SW) begin
						state_nxt = ST_EXPOSE;
						tmr_go    = 1'b1;
					end else begin
						state_nxt = ST_WAIT;
					end
				end
			end
		endcase

		// Hand a captured frame to the engine as soon as it is free.
		// A frame finished in this same cycle stays pending; clearing it here would lose it.
		if (ro_pend_r && (!ro_busy_r || readout_done_i)) begin
			ro_pend_nxt = finish;
			ro_busy_nxt = 1'b1;
			ro_req_nxt  = 1'b1;
		end
	end

	// Sequencer registers; strobe follows the exposing state directly.
	// The edge detector resets to the active level, so a trigger held active through reset starts nothing.
	always @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r       <= ST_IDLE;
			armed_r       <= 1'b0;
			ro_busy_r     <= 1'b0;
			ro_pend_r     <= 1'b0;
			done_cnt_r    <= {`TEC_FRM_W{1'b0}};
			act_d_r       <= 1'b1;
			strobe_o      <= 1'b0;
			readout_req_o <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			armed_r       <= armed_nxt;
			ro_busy_r     <= ro_busy_nxt;
			ro_pend_r     <= ro_pend_nxt;
			done_cnt_r    <= done_cnt_nxt;
			act_d_r       <= trig_act;
			strobe_o      <= (state_nxt == ST_EXPOSE);
			readout_req_o <= ro_req_nxt;
		end
	end

	// Configuration writes; readout rate and binning only pass through.
	// New settings act at once, even mid-exposure, so software should stop a capture first.
	always @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			// Source none at reset, so nothing moves until software asks.
			trigger_source_select_r <= `TEC_SRC_NONE;
			trigger_edge_select_r   <= 1'b0;
			readout_rate_o          <= 1'b0;
			binning_o               <= 2'h0;
			frames_r                <= `TEC_FRM_RST;
			expose_r                <= `TEC_EXP_RST;
		end else if (wr_i) begin
			if (addr_i == `TEC_REG_CTRL) begin
				trigger_source_select_r <= wr_data_i[`TEC_CTRL_SRC_HI:`TEC_CTRL_SRC_LO];
				trigger_edge_select_r   <= wr_data_i[`TEC_CTRL_EDGE];
				readout_rate_o          <= wr_data_i[`TEC_CTRL_RATE];
				binning_o               <= wr_data_i[`TEC_CTRL_BIN_HI:`TEC_CTRL_BIN_LO];
			end
			if (addr_i == `TEC_REG_FRAMES) begin
				frames_r <= wr_data_i[`TEC_FRM_W-1:0];
			end
			if (addr_i == `TEC_REG_EXPOSE) begin
				expose_r <= wr_data_i[`TEC_EXP_W-1:0];
			end
		end
	end

	// Status word gathers live sequencer state.
	// Reading it has no side effect, so software may poll it as often as it likes.
	assign status_w = {done_cnt_r, 8'h00, mode, strobe_o, ro_pend_r,
	                   ro_busy_r, armed_r, state_r};

	// Read data stand for exactly one cycle; unmapped and command read zero.
	always @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_data_o <= 32'h00000000;
		end else if (rd_i) begin
			case (addr_i)
				`TEC_REG_CTRL: begin
					rd_data_o <= {26'h0000000, binning_o, readout_rate_o,
					              trigger_edge_select_r, trigger_source_select_r};
				end
				`TEC_REG_FRAMES: begin
					rd_data_o <= {16'h0000, frames_r};
				end
				`TEC_REG_EXPOSE: begin
					rd_data_o <= {8'h00, expose_r};
				end
				`TEC_REG_STATUS: begin
					rd_data_o <= status_w;
				end
				default: begin
					rd_data_o <= 32'h00000000;
				end
			endcase
		end else begin
			rd_data_o <= 32'h00000000;
		end
	end
endmodule // tec_top

// ==== verification/tec_props.sv ====
`timescale 1ns/1ps
`include "tec_regs.vh"
// Checker on the top-level pins; it keeps its own shadow of the trigger settings.
module tec_props (
	// Clock and reset.
	input wire                   sys_clk_i,
	input wire                   reset_i,
	// Register port.
	input wire [`TEC_ADDR_W-1:0] addr_i,
	input wire [31:0]            wr_data_i,
	input wire                   wr_i,
	input wire                   rd_i,
	input wire [31:0]            rd_data_o,
	// Trigger, strobe and readout engine.
	input wire                   trigger_i,
	input wire                   strobe_o,
	input wire                   readout_req_o,
	input wire                   readout_done_i,
	input wire                   readout_rate_o,
	input wire [1:0]             binning_o
);
	reg  [1:0] src_r;
	reg        edge_r;
	reg        one_r;
	reg        busy_r;
	wire       act       = edge_r ? trigger_i : ~trigger_i;
	wire       hold_mode = (src_r == `TEC_SRC_LEVEL) || (src_r == `TEC_SRC_STD && one_r);
	wire [1:0] mode_e    = (src_r == `TEC_SRC_LEVEL) ? 2'h3 : (src_r == `TEC_SRC_STD) ? (one_r ? 2'h2 : 2'h1) : 2'h0;

	// Shadow of the settings; a readout is busy from request until done.
	always @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			src_r  <= 2'h0;
			edge_r <= 1'b0;
			one_r  <= 1'b1;
			busy_r <= 1'b0;
		end else begin
			if (wr_i && addr_i == `TEC_REG_CTRL) begin
				src_r  <= wr_data_i[1:0];
				edge_r <= wr_data_i[2];
			end
			if (wr_i && addr_i == `TEC_REG_FRAMES) begin
				one_r <= (wr_data_i[15:0] == 16'h0001);
			end
			if (readout_req_o) begin
				busy_r <= 1'b1;
			end else if (readout_done_i) begin
				busy_r <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	// Eight cycles covers the synchroniser and the output flop with margin.
	sequence s_bulb_late;
		(src_r == `TEC_SRC_LEVEL && strobe_o && !act) [*8];
	endsequence
	property p_bulb_end;   not s_bulb_late; endproperty
	property p_rate;       wr_i && addr_i == `TEC_REG_CTRL |=> readout_rate_o == $past(wr_data_i[3]); endproperty
	property p_bin;        wr_i && addr_i == `TEC_REG_CTRL |=> binning_o == $past(wr_data_i[5:4]); endproperty
	property p_mode;       rd_i && addr_i == `TEC_REG_STATUS |=> rd_data_o[7:6] == $past(mode_e); endproperty
	property p_strobe_st;  rd_i && addr_i == `TEC_REG_STATUS |=> rd_data_o[5] == $past(strobe_o); endproperty
	property p_req_after;  $fell(strobe_o) |-> ##[1:120] readout_req_o; endproperty
	property p_req_pulse;  readout_req_o |=> !readout_req_o; endproperty
	property p_ro_quiet;   busy_r && hold_mode |-> !$rose(strobe_o); endproperty

	a_bulb_end:  assert property (p_bulb_end) else $error("strobe outlived the bulb pulse");
	a_rate:      assert property (p_rate) else $error("rate pin differs from written bit");
	a_bin:       assert property (p_bin) else $error("binning pins differ from written field");
	a_mode:      assert property (p_mode) else $error("mode field does not match settings");
	a_strobe_st: assert property (p_strobe_st) else $error("status strobe bit differs from pin");
	a_req_after: assert property (p_req_after) else $error("no readout after exposure");
	a_req_pulse: assert property (p_req_pulse) else $error("readout request longer than one cycle");
	a_ro_quiet:  assert property (p_ro_quiet) else $error("exposure began during readout");
endmodule // tec_props

bind tec_top tec_props u_props (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
	.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .trigger_i(trigger_i), .strobe_o(strobe_o),
	.readout_req_o(readout_req_o), .readout_done_i(readout_done_i), .readout_rate_o(readout_rate_o),
	.binning_o(binning_o));

// ==== verification/tec_ro_model.sv ====
`timescale 1ns/1ps
// Readout engine stand-in; a slow answer keeps the trigger-ignore window wide.
module tec_ro_model #(
	parameter int DELAY = 100
) (
	input  wire  sys_clk_i,
	input  wire  reset_i,
	input  wire  req_i,
	output logic done_o
);
	int cnt_r;

	// Count down from each request; done lasts one cycle.
	always @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_r  <= 0;
			done_o <= 1'b0;
		end else begin
			done_o <= (cnt_r == 1);
			if (req_i) begin
				cnt_r <= DELAY;
			end else if (cnt_r != 0) begin
				cnt_r <= cnt_r - 1;
			end
		end
	end
endmodule // tec_ro_model

// ==== verification/test_triggered_exposure_control.sv ====
`timescale 1ns/1ps
`include "tec_regs.vh"
module test_triggered_exposure_control;
	logic                   sys_clk_i = 1'b0;
	logic                   reset_i   = 1'b1;
	logic [`TEC_ADDR_W-1:0] addr_i    = '0;
	logic [31:0]            wr_data_i = '0;
	logic                   wr_i      = 1'b0;
	logic                   rd_i      = 1'b0;
	logic                   trigger_i = 1'b0;
	wire  [31:0]            rd_data_o;
	wire                    strobe_o, readout_req_o, readout_done_i, readout_rate_o;
	wire  [1:0]             binning_o;
	int                     errors, check_count, cyc, n, k;
	logic [31:0]            d;
	// Settings rows: control value, frame count, expected mode.
	logic [5:0]  row_ctrl [6] = '{6'h00, 6'h09, 6'h31, 6'h1d, 6'h22, 6'h03};
	logic [15:0] row_frm  [6] = '{16'h1, 16'h0, 16'h1, 16'h2, 16'h5, 16'h1};
	logic [1:0]  row_mode [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h3, 2'h0};

	always #4 sys_clk_i = ~sys_clk_i;

	tec_top u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
		.rd_i(rd_i), .rd_data_o(rd_data_o), .trigger_i(trigger_i), .strobe_o(strobe_o), .readout_req_o(readout_req_o),
		.readout_done_i(readout_done_i), .readout_rate_o(readout_rate_o), .binning_o(binning_o));
	tec_ro_model u_ro (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(readout_req_o), .done_o(readout_done_i));

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk_i);
		addr_i    <= a;
		wr_data_i <= v;
		wr_i      <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample mid-cycle.
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		@(negedge sys_clk_i);
		v = rd_data_o;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Waits up to lim cycles for the strobe, counts its high cycles, then returns on a rising edge.
	task automatic pulse(input int lim, output int cnt);
		cnt = 0;
		for (int i = 0; i < lim && strobe_o !== 1'b1; i++) @(negedge sys_clk_i);
		while (strobe_o === 1'b1) begin
			@(negedge sys_clk_i);
			cnt++;
		end
		@(posedge sys_clk_i);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// A hang is cut short well above the few thousand cycles the tests need.
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			results();
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(`TEC_REG_CTRL, d);   chk(d, 32'h0);
		rd(`TEC_REG_FRAMES, d); chk(d, 32'h1);
		rd(`TEC_REG_EXPOSE, d); chk(d, 32'h3e8);
		rd(`TEC_REG_CMD, d);    chk(d, 32'h0);
		rd(8'h14, d);           chk(d, 32'h0);
		$display("test reset done");
		for (int r = 0; r < 6; r++) begin
			wr(`TEC_REG_CTRL, {26'h0, row_ctrl[r]});
			wr(`TEC_REG_FRAMES, {16'h0, row_frm[r]});
			rd(`TEC_REG_STATUS, d);
			chk({d[7:6], binning_o, readout_rate_o}, {row_mode[r], row_ctrl[r][5:3]});
		end
		$display("test modes done");
		// Rising edge, 2 us exposure, trigger toggled during readout.
		wr(`TEC_REG_CTRL, 32'h5);
		wr(`TEC_REG_FRAMES, 32'h1);
		wr(`TEC_REG_EXPOSE, 32'h2);
		wr(`TEC_REG_CMD, 32'h1);
		repeat (5) @(posedge sys_clk_i);
		trigger_i <= 1'b1;
		pulse(100, n);  chk(n >= 250 && n <= 251, 1);
		repeat (10) @(posedge sys_clk_i);
		trigger_i <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		trigger_i <= 1'b1;
		pulse(400, n);  chk(n, 0);
		trigger_i <= 1'b0;
		repeat (10) @(posedge sys_clk_i);
		trigger_i <= 1'b1;
		pulse(100, n);  chk(n >= 250 && n <= 251, 1);
		repeat (150) @(posedge sys_clk_i);
		wr(`TEC_REG_CMD, 32'h2);
		$display("test async done");
		// Falling activation; the pulse width sets the exposure.
		wr(`TEC_REG_CTRL, 32'h2);
		wr(`TEC_REG_CMD, 32'h1);
		fork
			pulse(200, n);
			begin
				repeat (10) @(posedge sys_clk_i);
				trigger_i <= 1'b0;
				repeat (100) @(posedge sys_clk_i);
				trigger_i <= 1'b1;
			end
		join
		chk(n >= 99 && n <= 101, 1);
		repeat (150) @(posedge sys_clk_i);
		wr(`TEC_REG_CMD, 32'h2);
		$display("test bulb done");
		// Streaming: a count of two stops by itself, zero runs until STOP; exposure overlaps readout.
		wr(`TEC_REG_CTRL, 32'h5);
		for (int c = 2; c >= 0; c -= 2) begin
			wr(`TEC_REG_FRAMES, c);
			wr(`TEC_REG_CMD, 32'h1);
			for (int i = 0; i < 3; i++) begin
				trigger_i <= 1'b0;
				repeat (5) @(posedge sys_clk_i);
				trigger_i <= 1'b1;
				if (i == 1) begin
					repeat (20) @(posedge sys_clk_i);
					rd(`TEC_REG_STATUS, d); chk({d[5], d[3]}, 32'h3);
				end
				pulse(400, n);  chk(n != 0, i < c || c == 0);
			end
			rd(`TEC_REG_STATUS, d);
			chk({d[31:16], d[2:0]}, (c == 2) ? 32'h10 : 32'h1d);
			wr(`TEC_REG_CMD, 32'h2);
		end
		$display("test streaming done");
		// Software capture of three frames with no trigger activity.
		wr(`TEC_REG_CTRL, 32'h0);
		wr(`TEC_REG_FRAMES, 32'h3);
		wr(`TEC_REG_CMD, 32'h1);
		k = 0;
		for (int i = 0; i < 4; i++) begin
			pulse(700, n);
			if (n != 0) k++;
		end
		chk(k, 3);
		rd(`TEC_REG_STATUS, d); chk(d[31:16], 32'h3);
		$display("test software done");
		results();
	end
endmodule // test_triggered_exposure_control
